//--- dcs_defines.svh
// Offsets, field positions, reset values and error types of the completion status block.
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH

// ==========================================================================
// Register map (byte offsets on the plain register port)
`define DCS_OFF_STATUS      4'h0
`define DCS_OFF_DATA        4'h1
`define DCS_OFF_CTRL        4'h2

// ==========================================================================
// Completion status byte fields
`define DCS_CS_ERR_BIT      1
`define DCS_CS_DRV_BIT      5

// ==========================================================================
// Handshake status bits
`define DCS_HS_BUSY_BIT     0
`define DCS_HS_REQ_BIT      1
`define DCS_HS_IRQ_BIT      2
`define DCS_HS_SENSE_BIT    3

// ==========================================================================
// Control register bits
`define DCS_CTRL_IRQEN_BIT  0
`define DCS_CTRL_RST_VAL    8'h00

// ==========================================================================
// Sense byte 0 fields and sense byte count
`define DCS_S0_VALID_BIT    7
`define DCS_S0_TYPE_LSB     4
`define DCS_SENSE_COUNT     3'h4

// ==========================================================================
// Error types
`define DCS_TYPE_DRIVE      2'h0
`define DCS_TYPE_MEDIA      2'h1
`define DCS_TYPE_CMD        2'h2
`define DCS_TYPE_DIAG       2'h3

`endif

//--- dcs_pkg.sv
// Types shared by the completion status block.
package dcs_pkg;

   // =======================================================================
   // Completion fault sources, one code per reportable condition.
   typedef enum logic [4:0] {
      DCS_F_NONE      = 5'h00,
      DCS_F_NO_INDEX  = 5'h01,
      DCS_F_NO_SEEKC  = 5'h02,
      DCS_F_WR_FAULT  = 5'h03,
      DCS_F_NOT_READY = 5'h04,
      DCS_F_NO_TRK0   = 5'h05,
      DCS_F_SEEKING   = 5'h06,
      DCS_F_ID_ECC    = 5'h07,
      DCS_F_DATA_ECC  = 5'h08,
      DCS_F_NO_MARK   = 5'h09,
      DCS_F_NO_SECTOR = 5'h0A,
      DCS_F_SEEK_ERR  = 5'h0B,
      DCS_F_CORR_ECC  = 5'h0C,
      DCS_F_BAD_TRACK = 5'h0D,
      DCS_F_BAD_CMD   = 5'h0E,
      DCS_F_BAD_ADDR  = 5'h0F,
      DCS_F_RAM       = 5'h10,
      DCS_F_CHECKSUM  = 5'h11,
      DCS_F_ECC_GEN   = 5'h12
   } dcs_fault_e;

   // Phases of the result handshake.
   typedef enum logic [2:0] {
      DCS_IDLE   = 3'b001,
      DCS_STATUS = 3'b010,
      DCS_SENSE  = 3'b100
   } dcs_state_e;

endpackage

//--- dcs_completion_status.sv
// Completion status byte and sense byte reporting of a fixed disk controller.
//
// Local design decisions: the register offsets and the strobed register port.
`include "dcs_defines.svh"

module dcs_completion_status
   import dcs_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // Register port
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrStb,
   input  wire logic       regRdStb,
   output logic      [7:0] regRdData,
   // Command completion from the execution engine
   input  wire logic       cmdDone,
   input  wire logic [4:0] cmdFault,
   input  wire logic       cmdDrive,
   input  wire logic [4:0] cmdHead,
   input  wire logic [9:0] cmdCylinder,
   input  wire logic [5:0] cmdSector,
   input  wire logic       cmdHasAddress,
   input  wire logic       cmdStart,
   // Controller status toward the host and engine
   output logic            busy,
   output logic            irq,
   output logic            retryInhibit
);

   // ========================================================================
   // Fault decoding

   // Maps a fault source to its {type, code} pair for sense byte 0.
   function automatic logic [5:0] faultTypeCode(input logic [4:0] f);
      logic [5:0] tc;
      tc = {`DCS_TYPE_DRIVE, 4'h0};
      case (f)
         DCS_F_NONE:      tc = {`DCS_TYPE_DRIVE, 4'h0};
         DCS_F_NO_INDEX:  tc = {`DCS_TYPE_DRIVE, 4'h1};
         DCS_F_NO_SEEKC:  tc = {`DCS_TYPE_DRIVE, 4'h2};
         DCS_F_WR_FAULT:  tc = {`DCS_TYPE_DRIVE, 4'h3};
         DCS_F_NOT_READY: tc = {`DCS_TYPE_DRIVE, 4'h4};
         DCS_F_NO_TRK0:   tc = {`DCS_TYPE_DRIVE, 4'h6};
         DCS_F_SEEKING:   tc = {`DCS_TYPE_DRIVE, 4'h8};
         DCS_F_ID_ECC:    tc = {`DCS_TYPE_MEDIA, 4'h0};
         DCS_F_DATA_ECC:  tc = {`DCS_TYPE_MEDIA, 4'h1};
         DCS_F_NO_MARK:   tc = {`DCS_TYPE_MEDIA, 4'h2};
         DCS_F_NO_SECTOR: tc = {`DCS_TYPE_MEDIA, 4'h4};
         DCS_F_SEEK_ERR:  tc = {`DCS_TYPE_MEDIA, 4'h5};
         DCS_F_CORR_ECC:  tc = {`DCS_TYPE_MEDIA, 4'h8};
         DCS_F_BAD_TRACK: tc = {`DCS_TYPE_MEDIA, 4'h9};
         DCS_F_BAD_CMD:   tc = {`DCS_TYPE_CMD, 4'h0};
         DCS_F_BAD_ADDR:  tc = {`DCS_TYPE_CMD, 4'h1};
         DCS_F_RAM:       tc = {`DCS_TYPE_DIAG, 4'h0};
         DCS_F_CHECKSUM:  tc = {`DCS_TYPE_DIAG, 4'h1};
         DCS_F_ECC_GEN:   tc = {`DCS_TYPE_DIAG, 4'h2};
         default:         tc = {`DCS_TYPE_CMD, 4'h0};
      endcase
      return tc;
   endfunction

   // Handshake state, declared early because result capture reads it.
   dcs_state_e state_q;
   dcs_state_e state_d;

   // Decoded register accesses.
   logic rdData;
   logic rdStatus;
   logic wrCtrl;
   logic rdCtrl;

   assign rdData   = regRdStb && (regAddr == `DCS_OFF_DATA);
   assign rdStatus = regRdStb && (regAddr == `DCS_OFF_STATUS);
   assign rdCtrl   = regRdStb && (regAddr == `DCS_OFF_CTRL);
   assign wrCtrl   = regWrStb && (regAddr == `DCS_OFF_CTRL);

   // ========================================================================
   // Control register

   logic [7:0] ctrl_q;

   // Interrupt enable lives here; other bits are held but unused.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_q <= `DCS_CTRL_RST_VAL;
      end else if (wrCtrl) begin
         ctrl_q <= regWrData;
      end
   end

   // ========================================================================
   // Captured result of the last command

   logic [7:0] compStatus_q;
   logic [7:0] sense_q [0:3];
   logic       errLatched_q;

   // Result bytes are frozen at completion so a later command cannot
   // disturb sense data the host has not yet read.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         compStatus_q <= 8'h00;
         errLatched_q <= 1'b0;
         sense_q[0]   <= 8'h00;
         sense_q[1]   <= 8'h00;
         sense_q[2]   <= 8'h00;
         sense_q[3]   <= 8'h00;
      end else if (cmdDone && state_q == DCS_IDLE) begin
         compStatus_q                  <= 8'h00;
         compStatus_q[`DCS_CS_ERR_BIT] <= (cmdFault != DCS_F_NONE);
         compStatus_q[`DCS_CS_DRV_BIT] <= cmdDrive;
         errLatched_q                  <= (cmdFault != DCS_F_NONE);
         sense_q[0] <= {cmdHasAddress, 1'b0, faultTypeCode(cmdFault)};
         sense_q[1] <= {2'b00, cmdDrive, cmdHead};
         sense_q[2] <= {cmdCylinder[9:8], cmdSector};
         sense_q[3] <= cmdCylinder[7:0];
      end
   end

   // ========================================================================
   // Result handshake state machine

   logic [2:0] senseIdx_q;
   logic       busy_q;

   // Status byte first, then the four sense bytes when the status byte flags an error.
   always_comb begin
      state_d = state_q;
      case (state_q)
         DCS_IDLE: begin
            if (cmdDone) begin
               state_d = DCS_STATUS;
            end
         end
         DCS_STATUS: begin
            if (rdData) begin
               state_d = errLatched_q ? DCS_SENSE : DCS_IDLE;
            end
         end
         DCS_SENSE: begin
            if (rdData && senseIdx_q == `DCS_SENSE_COUNT - 3'h1) begin
               state_d = DCS_IDLE;
            end
         end
         default: begin
            state_d = DCS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q <= DCS_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Walks the sense stack one byte per data read.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         senseIdx_q <= 3'h0;
      end else if (state_q != DCS_SENSE) begin
         senseIdx_q <= 3'h0;
      end else if (rdData) begin
         senseIdx_q <= senseIdx_q + 3'h1;
      end
   end

   // Busy rises with a command and falls when the status byte is taken.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
      end else if (state_q == DCS_STATUS && rdData) begin
         busy_q <= 1'b0;
      end else if (cmdStart || cmdDone) begin
         busy_q <= 1'b1;
      end
   end

   assign busy = busy_q;

   // ========================================================================
   // Interrupt and retry inhibit

   logic irq_q;
   logic retryInh_q;

   // Interrupt is a level from an enabled completion until the status byte is read or the enable is cleared.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else if (cmdDone && state_q == DCS_IDLE) begin
         irq_q <= ctrl_q[`DCS_CTRL_IRQEN_BIT];
      end else if (rdData || !ctrl_q[`DCS_CTRL_IRQEN_BIT]) begin
         irq_q <= 1'b0;
      end
   end

   assign irq = irq_q;

   // A bad track is final, so the engine is told not to retry it.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         retryInh_q <= 1'b0;
      end else begin
         retryInh_q <= (cmdFault == DCS_F_BAD_TRACK);
      end
   end

   assign retryInhibit = retryInh_q;

   // ========================================================================
   // Read data path

   logic [7:0] hsStatus;
   logic [7:0] dataOut;

   // Handshake status is read-only and never pops the data stack.
   always_comb begin
      hsStatus                    = 8'h00;
      hsStatus[`DCS_HS_BUSY_BIT]  = busy_q;
      hsStatus[`DCS_HS_REQ_BIT]   = (state_q != DCS_IDLE);
      hsStatus[`DCS_HS_IRQ_BIT]   = irq_q;
      hsStatus[`DCS_HS_SENSE_BIT] = (state_q == DCS_SENSE);
   end

   // The data register shows only the byte on top of the result stack.
   always_comb begin
      case (state_q)
         DCS_STATUS: dataOut = compStatus_q;
         DCS_SENSE:  dataOut = sense_q[senseIdx_q[1:0]];
         default:    dataOut = 8'h00;
      endcase
   end

   // Read data stand only in the cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         regRdData <= 8'h00;
      end else if (rdData) begin
         regRdData <= dataOut;
      end else if (rdStatus) begin
         regRdData <= hsStatus;
      end else if (rdCtrl) begin
         regRdData <= ctrl_q;
      end else begin
         regRdData <= 8'h00;
      end
   end

endmodule

//--- dcs_completion_status_chk.sv
// Checker of the completion status block, bound to its top module.
module dcs_completion_status_chk
   import dcs_pkg::*;
(
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWrStb,
   input wire logic       regRdStb,
   input wire logic [7:0] regRdData,
   // Command and status
   input wire logic       cmdDone,
   input wire logic [4:0] cmdFault,
   input wire logic       cmdStart,
   input wire logic       busy,
   input wire logic       irq,
   input wire logic       retryInhibit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic irqEn_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // =====================================================================
   // Shadow of the interrupt enable, since the control register is not a port.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irqEn_q <= 1'b0;
      end else if (regWrStb && regAddr == 4'h2) begin
         irqEn_q <= regWrData[0];
      end
   end
   // =====================================================================
   // Port relations.
   property p_rdSlot; !$past(regRdStb) |-> regRdData == 8'h00; endproperty
   a_rdSlot: assert property (p_rdSlot) else $error("read data outside slot");
   property p_unmap; regRdStb && regAddr > 4'h2 |=> regRdData == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_busyUp; cmdStart |=> busy; endproperty
   a_busyUp: assert property (p_busyUp) else $error("busy not raised");
   property p_busyHold; busy && !(regRdStb && regAddr == 4'h1) |=> busy; endproperty
   a_busyHold: assert property (p_busyHold) else $error("busy dropped early");
   property p_busyDrop;
      $fell(busy) |-> $past(regRdStb) && $past(regAddr) == 4'h1 && (regRdData & 8'hDD) == 8'h00;
   endproperty
   a_busyDrop: assert property (p_busyDrop) else $error("bad busy release");
   property p_irqUp; cmdDone && irqEn_q |=> irq; endproperty
   a_irqUp: assert property (p_irqUp) else $error("interrupt missing");
   property p_irqDrop; $fell(irq) |-> $past(regRdStb) || $past(regWrStb); endproperty
   a_irqDrop: assert property (p_irqDrop) else $error("interrupt lost");
   property p_retry; retryInhibit == ($past(cmdFault) == DCS_F_BAD_TRACK); endproperty
   a_retry: assert property (p_retry) else $error("retry inhibit wrong");
endmodule

bind dcs_completion_status dcs_completion_status_chk i_chk (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
   .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .cmdDone(cmdDone),
   .cmdFault(cmdFault), .cmdStart(cmdStart), .busy(busy), .irq(irq),
   .retryInhibit(retryInhibit)
);

//--- dcs_host_model.sv
// Host processor model: master of the block's register port.
module dcs_host_model (
   // Clock
   input  wire logic       clk_sys,
   // Register port
   output logic      [3:0] regAddr,
   output logic      [7:0] regWrData,
   output logic            regWrStb,
   output logic            regRdStb,
   input  wire logic [7:0] regRdData
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus quiet at time zero.
   initial begin
      regAddr = 4'h0;
      regWrData = 8'h00;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
   end
   // One-cycle write; address and data are inverted afterwards so stale values never help.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr   <= a;
      regWrData <= d;
      regWrStb  <= 1'b1;
      @(posedge clk_sys);
      regWrStb  <= 1'b0;
      regAddr   <= ~a;
      regWrData <= ~d;
   endtask
   // One-cycle read; data is taken in the cycle after the strobe only.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regAddr  <= a;
      regRdStb <= 1'b1;
      @(posedge clk_sys);
      regRdStb <= 1'b0;
      regAddr  <= ~a;
      #1;
      d = regRdData;
   endtask
   // Result fetch: status byte, then four sense bytes when it flags an error.
   task automatic fetch(output logic [7:0] st, output logic [31:0] sn);
      logic [7:0] b;
      sn = 32'h0;
      rd(4'h1, st);
      if (st[1]) begin
         for (int k = 0; k < 4; k++) begin
            rd(4'h1, b);
            sn = {sn[23:0], b};
         end
      end
   endtask
endmodule

//--- tb_dcs_completion_status.sv
// Testbench of the completion status block: commands, status and sense bytes.
module tb_dcs_completion_status;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [3:0]  regAddr;
   logic [7:0]  regWrData;
   logic        regWrStb;
   logic        regRdStb;
   logic [7:0]  regRdData;
   logic        cmdDone = 1'b0;
   logic [4:0]  cmdFault = 5'h00;
   logic        cmdDrive = 1'b0;
   logic [4:0]  cmdHead = 5'h00;
   logic [9:0]  cmdCylinder = 10'h000;
   logic [5:0]  cmdSector = 6'h00;
   logic        cmdHasAddress = 1'b0;
   logic        cmdStart = 1'b0;
   logic        busy;
   logic        irq;
   logic        retryInhibit;
   int          mismatches = 0;
   int          num_checks = 0;
   int          cycles = 0;
   logic [7:0]  st;
   logic [31:0] sn;
   // Expected {type, code} for each fault source, in enum order.
   logic [7:0]  tc [19] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h10, 8'h11,
      8'h12, 8'h14, 8'h15, 8'h18, 8'h19, 8'h20, 8'h21, 8'h30, 8'h31, 8'h32};
   // =====================================================================
   // Clock, hang guard and instances.
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         mismatches++;
         $display("mismatch at %0t: timeout", $time);
         final_report();
      end
   end
   dcs_completion_status i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
      .cmdDone(cmdDone), .cmdFault(cmdFault), .cmdDrive(cmdDrive), .cmdHead(cmdHead),
      .cmdCylinder(cmdCylinder), .cmdSector(cmdSector), .cmdHasAddress(cmdHasAddress),
      .cmdStart(cmdStart), .busy(busy), .irq(irq), .retryInhibit(retryInhibit));
   dcs_host_model i_host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData));
   // =====================================================================
   // Compare, command and closing tasks.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One command ending in fault f; the fields vary with f so every bit but sector bit 5 moves.
   task automatic run(input int f, input logic en);
      logic [9:0] cy;
      cy = 10'(f * 53 + 512);
      @(posedge clk_sys);
      cmdStart <= 1'b1;
      @(posedge clk_sys);
      cmdStart      <= 1'b0;
      cmdDone       <= 1'b1;
      cmdFault      <= 5'(f);
      cmdDrive      <= f[0];
      cmdHead       <= 5'(f + 3);
      cmdCylinder   <= cy;
      cmdSector     <= 6'(63 - f);
      cmdHasAddress <= f[1];
      @(posedge clk_sys);
      cmdDone <= 1'b0;
      #1;
      chk({5'h00, busy, irq, retryInhibit}, {5'h00, 1'b1, en, f == 13});
      i_host.rd(4'h0, st);
      chk(st & 8'h0F, {5'h00, en, 2'b11});
      i_host.fetch(st, sn);
      chk(st, {2'b00, f[0], 3'b000, f != 0, 1'b0});
      if (f != 0) begin
         chk(sn[31:24], {f[1], 1'b0, tc[f][5:0]});
         chk(sn[23:16], {2'b00, f[0], 5'(f + 3)});
         chk(sn[15:8], {cy[9:8], 6'(63 - f)});
         chk(sn[7:0], cy[7:0]);
      end
      chk({6'h00, busy, irq}, 8'h00);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // =====================================================================
   // Main sequence: idle and unmapped reads, a masked command, then every fault.
   initial begin
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      i_host.rd(4'h1, st);
      chk(st, 8'h00);
      i_host.rd(4'h5, st);
      chk(st, 8'h00);
      run(13, 1'b0);
      i_host.wr(4'h2, 8'h01);
      for (int f = 0; f < 19; f++) begin
         run(f, 1'b1);
      end
      run(0, 1'b1);
      i_host.rd(4'h1, st);
      chk(st, 8'h00);
      final_report();
   end
endmodule
